// [verilog/pwmcc_top.v]
// Four-channel PWM core: clock generator, channel counters, comparators,
// dead-time, override and fault forcing, with an APB register slave.
// Assumes all inputs synchronous to core_clk; clk_en models peripheral gating.
// Notes on behaviour
// RULE1 - Prescaler gives clock divided by 1 through 1024, eleven taps.
// RULE2 - Two separate linear dividers, ratios 1 to 255.
// RULE3 - Each divider divides its selected prescaler tap by its ratio.
// RULE4 - Divider fields reset to zero; ratio zero stops that clock.
// RULE5 - At reset or clock gated, only undivided tap is active. When gated, pre_tick[0] follows clk_en low, so no tap is active.
// RULE6 - Thirteen clocks; each channel picks one, select resets to zero.
// RULE7 - Each channel has a 16-bit counter stepped by its clock.
// RULE8 - Sync bit makes comparator use channel 0 counter.
// RULE9 - Fault forcing overrides everything: 0, 1 or released pin.
// RULE10 - Override forces both channel outputs after the dead-time stage.
// RULE11 - Comparator checks counter against period and duty continuously.
// RULE12 - Left-aligned default: count up to period then restart.
// RULE13 - Center-aligned: up to period then down to 0, double period.
// RULE14 - Polarity bit is the level at period start; reset gives low.
// RULE15 - Start level held for duty clock periods, opposite level afterwards.
// RULE16 - Fixed low at duty=period pol 0, or duty=0 pol 1.
// RULE17 - Fixed high when enabled at duty=0 pol 0, or duty=period pol 1.
// RULE18 - Software sets polarity before enabling and keeps it while running.
// RULE19 - Event at period end; center also at half when half-select set.
// RULE20 - Fault 0 oscillator, 1 converter, 2-7 pins; internal ones active high.
// RULE21 - Gating the clock freezes state; operation resumes where it stopped.
// RULE22 - Software enables the peripheral clock before use.
// RULE23 - Dead-time stage makes complementary outputs with delayed rising edges.
// RULE24 - Divided clocks are single-cycle enables in the core clock domain.
// RULE25 - Center mode output symmetric: same level up and down per value.
//
// Our own choices: the APB register port and the register addresses.
`include "pwmcc_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module pwmcc_top #(
   parameter CH   = 4,
   parameter CW   = 16,
   parameter NF   = 8,
   parameter DTW  = 12,
   parameter PSW  = 10
) (
   input  wire          core_clk,
   input  wire          rst,
   input  wire          clk_en,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output wire          pready,
   output reg  [31:0]   prdata,
   output reg           pslverr,
   input  wire [NF-1:0] fault_in,
   output wire [CH-1:0] compare_out,
   output wire [CH-1:0] counter_event,
   output reg  [CH-1:0] pin_high_side,
   output reg  [CH-1:0] pin_high_side_oe,
   output reg  [CH-1:0] pin_low_side,
   output reg  [CH-1:0] pin_low_side_oe
);
   // Bus slave: one wait state, so read data always comes from a flop
   reg            ready_reg;
   wire           acc = psel & penable & clk_en;
   wire           wr  = acc & ready_reg & pwrite;
   assign pready = ready_reg;

   reg [7:0]      divider_a_ratio;
   reg [3:0]      divider_a_source;
   reg [7:0]      divider_b_ratio;
   reg [3:0]      divider_b_source;
   reg [CH-1:0]   enable_reg;
   reg [CH-1:0]   sync_follow_bit;
   reg [CH-1:0]   ovr_sel_reg;
   reg [CH-1:0]   ovr_hi_reg;
   reg [CH-1:0]   ovr_lo_reg;
   reg [NF-1:0]   fault_polarity;
   reg [4*CH-1:0] fault_val_reg;
   reg [CH-1:0]   evt_reg;
   reg [31:0]     mode_mem   [0:CH-1];
   reg [CW-1:0]   period_mem [0:CH-1];
   reg [CW-1:0]   duty_mem   [0:CH-1];
   reg [31:0]     dead_mem   [0:CH-1];
   wire [CW*CH-1:0] cnt_all;
   wire [CH-1:0]    evt_pulse;
   wire [NF-1:0]    fault_act;
   integer        i;

   wire       in_ch  = paddr >= `PWMCC_A_CH_BASE && paddr <= `PWMCC_A_CH_END;
   wire       in_cnt = paddr >= `PWMCC_A_CNT_BASE && paddr <= `PWMCC_A_CNT_END;
   wire [7:0] ch_off = paddr - `PWMCC_A_CH_BASE;
   wire [1:0] ch_idx = ch_off[5:4];
   wire [1:0] ch_reg = ch_off[3:2];
   wire [1:0] cn_idx = paddr[3:2];
   reg  [31:0] rd_next;
   reg         err_next;

   always @* begin
      rd_next  = 32'h0000_0000;
      err_next = 1'b0;
      case (paddr)
         `PWMCC_A_CLK:   rd_next = {4'h0, divider_b_source, divider_b_ratio,
                                    4'h0, divider_a_source, divider_a_ratio};
         `PWMCC_A_ENA:   rd_next[CH-1:0] = enable_reg;
         `PWMCC_A_SYNC:  rd_next[CH-1:0] = sync_follow_bit;
         `PWMCC_A_OVR:   rd_next[3*CH-1:0] = {ovr_lo_reg, ovr_hi_reg, ovr_sel_reg};
         `PWMCC_A_FAULT_POLARITY:  rd_next[NF-1:0] = fault_polarity;
         `PWMCC_A_FVAL:  rd_next[4*CH-1:0] = fault_val_reg;
         `PWMCC_A_EVT:   rd_next[CH-1:0] = evt_reg;
         `PWMCC_A_FSTAT: rd_next[2*NF-1:0] = {fault_act, fault_in};
         default: begin
            if (in_ch) begin
               case (ch_reg)
                  `PWMCC_CH_MODE:   rd_next = mode_mem[ch_idx];
                  `PWMCC_CH_PERIOD: rd_next[CW-1:0] = period_mem[ch_idx];
                  `PWMCC_CH_DUTY:   rd_next[CW-1:0] = duty_mem[ch_idx];
                  default:          rd_next = dead_mem[ch_idx];
               endcase
            end else if (in_cnt) begin
               rd_next[CW-1:0] = cnt_all[cn_idx*CW +: CW];
            end else begin
               err_next = 1'b1;
            end
         end
      endcase
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ready_reg        <= 1'b0;
         prdata           <= 32'h0000_0000;
         pslverr          <= 1'b0;
         divider_a_ratio  <= 8'h00; // RULE4
         divider_a_source <= 4'h0; // RULE4
         divider_b_ratio  <= 8'h00; // RULE4
         divider_b_source <= 4'h0; // RULE4
         enable_reg       <= {CH{1'b0}};
         sync_follow_bit  <= {CH{1'b0}};
         ovr_sel_reg      <= {CH{1'b0}};
         ovr_hi_reg       <= {CH{1'b0}};
         ovr_lo_reg       <= {CH{1'b0}};
         fault_polarity   <= `PWMCC_FAULT_POLARITY_RST; // RULE20
         fault_val_reg    <= {4*CH{1'b0}};
         evt_reg          <= {CH{1'b0}};
         for (i = 0; i < CH; i = i + 1) begin
            mode_mem[i]   <= 32'h0000_0000; // RULE6 RULE14
            period_mem[i] <= {CW{1'b0}};
            duty_mem[i]   <= {CW{1'b0}};
            dead_mem[i]   <= 32'h0000_0000;
         end
      end else if (clk_en) begin // RULE21
         ready_reg <= acc & ~ready_reg;
         // Error flag stands only while pready does
         pslverr   <= acc & ~ready_reg & err_next;
         if (acc & ~ready_reg)
            prdata <= pwrite ? 32'h0000_0000 : rd_next;
         // Set beats a same-cycle write-one clear
         evt_reg <= (evt_reg & ~((wr && paddr == `PWMCC_A_EVT) ?
                     pwdata[CH-1:0] : {CH{1'b0}})) | evt_pulse;
         if (wr) begin
            case (paddr)
               `PWMCC_A_CLK: begin
                  divider_a_ratio  <= pwdata[7:0];
                  divider_a_source <= pwdata[11:8];
                  divider_b_ratio  <= pwdata[23:16];
                  divider_b_source <= pwdata[27:24];
               end
               `PWMCC_A_ENA:  enable_reg <= pwdata[CH-1:0];
               `PWMCC_A_SYNC: sync_follow_bit <= pwdata[CH-1:0];
               `PWMCC_A_OVR: begin
                  ovr_sel_reg <= pwdata[CH-1:0];
                  ovr_hi_reg  <= pwdata[2*CH-1:CH];
                  ovr_lo_reg  <= pwdata[3*CH-1:2*CH];
               end
               `PWMCC_A_FAULT_POLARITY: fault_polarity <= pwdata[NF-1:0];
               `PWMCC_A_FVAL: fault_val_reg <= pwdata[4*CH-1:0];
               default: begin
                  if (in_ch) begin
                     case (ch_reg)
                        `PWMCC_CH_MODE:   mode_mem[ch_idx] <= pwdata;
                        `PWMCC_CH_PERIOD: period_mem[ch_idx] <= pwdata[CW-1:0];
                        `PWMCC_CH_DUTY:   duty_mem[ch_idx] <= pwdata[CW-1:0];
                        default:          dead_mem[ch_idx] <= pwdata;
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // Clock generator: every divided clock is a one-cycle enable
   reg  [PSW-1:0] pre_cnt_reg;
   wire [PSW:0]   pre_tick;
   genvar g;
   assign pre_tick[0] = clk_en; // RULE1 RULE5
   generate
      for (g = 1; g <= PSW; g = g + 1) begin : gen_pre
         assign pre_tick[g] = clk_en & (&pre_cnt_reg[g-1:0]); // RULE1 RULE24
      end
   endgenerate

   always @(posedge core_clk or posedge rst) begin
      if (rst)
         pre_cnt_reg <= {PSW{1'b0}}; // RULE5
      else if (clk_en)
         pre_cnt_reg <= pre_cnt_reg + 1'b1;
   end

   reg [7:0] div_a_cnt_reg;
   reg [7:0] div_b_cnt_reg;
   wire src_a = divider_a_source <= PSW ? pre_tick[divider_a_source] : 1'b0; // RULE3
   wire src_b = divider_b_source <= PSW ? pre_tick[divider_b_source] : 1'b0; // RULE3
   wire hit_a = src_a && div_a_cnt_reg >= divider_a_ratio - 8'h01;
   wire hit_b = src_b && div_b_cnt_reg >= divider_b_ratio - 8'h01;
   wire divided_clock_a = hit_a && divider_a_ratio != 8'h00; // RULE2 RULE4
   wire divided_clock_b = hit_b && divider_b_ratio != 8'h00; // RULE2 RULE4

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_a_cnt_reg <= 8'h00;
         div_b_cnt_reg <= 8'h00;
      end else if (clk_en) begin
         if (divider_a_ratio == 8'h00 || hit_a)
            div_a_cnt_reg <= 8'h00; // RULE2
         else if (src_a)
            div_a_cnt_reg <= div_a_cnt_reg + 8'h01;
         if (divider_b_ratio == 8'h00 || hit_b)
            div_b_cnt_reg <= 8'h00; // RULE2
         else if (src_b)
            div_b_cnt_reg <= div_b_cnt_reg + 8'h01;
      end
   end

   wire [12:0] clk_set = {divided_clock_b, divided_clock_a, pre_tick}; // RULE6

   // Level-mode fault detection on each input
   assign fault_act = ~(fault_in ^ fault_polarity); // RULE20

   // Channels
   generate
      for (g = 0; g < CH; g = g + 1) begin : gen_ch
         wire [31:0]   mode   = mode_mem[g];
         wire [CW-1:0] period = period_mem[g];
         wire [CW-1:0] duty   = duty_mem[g];
         wire [31:0]   dead   = dead_mem[g];
         wire          center = mode[`PWMCC_M_CENTER];
         wire          pol    = mode[`PWMCC_M_POL];
         wire          event_half_select    = mode[`PWMCC_M_CES];
         wire          dte    = mode[`PWMCC_M_DTE];
         wire [3:0]    sel    = mode[3:0];
         wire          tick   = sel <= `PWMCC_SEL_B ? clk_set[sel] : 1'b0; // RULE6
         // Sync channels also use channel 0's fault enables
         wire [NF-1:0] fen    = sync_follow_bit[g] ? mode_mem[0][31:24] : mode[31:24];
         wire          fault  = enable_reg[g] & |(fault_act & fen); // RULE9
         reg  [CW-1:0] cnt_reg;
         reg           down_reg;
         reg           oc_reg;
         reg           oc_d_reg;
         reg  [DTW-1:0] dt_reg;
         reg           dth_reg;
         reg           dtl_reg;
         reg           evt_reg_c;
         wire [CW-1:0] cmp_cnt = sync_follow_bit[g] ? cnt_all[CW-1:0] : cnt_reg; // RULE8
         wire          top  = cnt_reg >= period;
         wire          lend = cnt_reg >= period - 1'b1;
         reg           oc_next;
         reg           ev_next;
         assign cnt_all[g*CW +: CW] = cnt_reg;
         assign compare_out[g]   = oc_reg;
         assign counter_event[g] = evt_reg_c;
         assign evt_pulse[g]     = evt_reg_c;

         always @* begin
            ev_next = 1'b0;
            if (enable_reg[g] && tick) begin
               if (!center)
                  ev_next = lend || period == {CW{1'b0}}; // RULE19
               else if (down_reg)
                  ev_next = cnt_reg <= {{CW-1{1'b0}}, 1'b1}; // RULE19
               else
                  // Half event on the tick that reaches the top, mirroring the end event
                  ev_next = event_half_select && cnt_reg == period - 1'b1; // RULE19
            end
            // Symmetric compare: level depends only on the count value
            if (!enable_reg[g])
               oc_next = 1'b0;
            else if (duty >= period)
               oc_next = pol; // RULE16 RULE17
            else if (duty == {CW{1'b0}})
               oc_next = ~pol; // RULE16 RULE17
            else
               oc_next = cmp_cnt < duty ? pol : ~pol; // RULE11 RULE14 RULE15 RULE25
         end

         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               cnt_reg   <= {CW{1'b0}};
               down_reg  <= 1'b0;
               oc_reg    <= 1'b0;
               oc_d_reg  <= 1'b0;
               dt_reg    <= {DTW{1'b0}};
               dth_reg   <= 1'b0;
               dtl_reg   <= 1'b0;
               evt_reg_c <= 1'b0;
            end else if (clk_en) begin // RULE21
               oc_reg    <= oc_next;
               oc_d_reg  <= oc_reg;
               evt_reg_c <= ev_next;
               if (!enable_reg[g] || fault) begin
                  cnt_reg  <= {CW{1'b0}}; // RULE9
                  down_reg <= 1'b0;
               end else if (tick) begin // RULE7
                  if (!center) begin
                     if (lend || period == {CW{1'b0}})
                        cnt_reg <= {CW{1'b0}}; // RULE12
                     else
                        cnt_reg <= cnt_reg + 1'b1;
                  end else if (!down_reg) begin
                     if (top) begin
                        down_reg <= 1'b1; // RULE13
                        cnt_reg  <= cnt_reg - 1'b1;
                     end else
                        cnt_reg <= cnt_reg + 1'b1;
                  end else if (cnt_reg <= {{CW-1{1'b0}}, 1'b1}) begin
                     down_reg <= 1'b0; // RULE13
                     cnt_reg  <= {CW{1'b0}};
                  end else
                     cnt_reg <= cnt_reg - 1'b1;
               end
               // Dead-time: each side rises only after its own delay
               if (oc_reg != oc_d_reg) begin
                  dt_reg  <= oc_reg ? dead[DTW-1:0] : dead[16 +: DTW]; // RULE23
                  dth_reg <= 1'b0;
                  dtl_reg <= 1'b0;
               end else if (dt_reg != {DTW{1'b0}}) begin
                  if (tick)
                     dt_reg <= dt_reg - 1'b1;
               end else begin
                  dth_reg <= oc_reg; // RULE23
                  dtl_reg <= ~oc_reg;
               end
            end
         end

         wire deadtime_high_out = dte ? dth_reg : oc_reg;
         wire deadtime_low_out  = dte ? dtl_reg : ~oc_reg;
         wire override_high_out = ovr_sel_reg[g] ? ovr_hi_reg[g] : deadtime_high_out; // RULE10
         wire override_low_out  = ovr_sel_reg[g] ? ovr_lo_reg[g] : deadtime_low_out; // RULE10

         always @(posedge core_clk or posedge rst) begin
            if (rst) begin
               pin_high_side[g]    <= 1'b0;
               pin_low_side[g]     <= 1'b0;
               pin_high_side_oe[g] <= 1'b1;
               pin_low_side_oe[g]  <= 1'b1;
            end else if (clk_en) begin
               if (fault) begin
                  pin_high_side[g]    <= fault_val_reg[g]; // RULE9
                  pin_low_side[g]     <= fault_val_reg[CH+g];
                  pin_high_side_oe[g] <= ~fault_val_reg[2*CH+g];
                  pin_low_side_oe[g]  <= ~fault_val_reg[3*CH+g];
               end else begin
                  pin_high_side[g]    <= override_high_out;
                  pin_low_side[g]     <= override_low_out;
                  pin_high_side_oe[g] <= 1'b1;
                  pin_low_side_oe[g]  <= 1'b1;
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [verilog/pwmcc_regs.vh]
// Register map, field positions and reset values of the PWM channel core.
// Assumes a 32-bit APB slave with word-aligned byte addresses.
`ifndef PWMCC_REGS_VH
`define PWMCC_REGS_VH
`define PWMCC_A_CLK      8'h00
`define PWMCC_A_ENA      8'h04
`define PWMCC_A_SYNC     8'h08
`define PWMCC_A_OVR      8'h0C
`define PWMCC_A_FAULT_POLARITY     8'h10
`define PWMCC_A_FVAL     8'h14
`define PWMCC_A_EVT      8'h18
`define PWMCC_A_FSTAT    8'h1C
`define PWMCC_A_CH_BASE  8'h20
`define PWMCC_A_CH_END   8'h5F
`define PWMCC_A_CNT_BASE 8'h60
`define PWMCC_A_CNT_END  8'h6F
`define PWMCC_CH_MODE    2'h0
`define PWMCC_CH_PERIOD  2'h1
`define PWMCC_CH_DUTY    2'h2
`define PWMCC_CH_DEAD    2'h3
`define PWMCC_FAULT_POLARITY_RST   8'h03
`define PWMCC_SEL_A      4'hB
`define PWMCC_SEL_B      4'hC
`define PWMCC_M_CENTER   8
`define PWMCC_M_POL      9
`define PWMCC_M_CES      10
`define PWMCC_M_DTE      16
`endif

// [verif/pwmcc_asserts.sv]
// Port-level checker of the APB handshake and the clock-gating freeze.
// Assumes it is bound to pwmcc_top; rst is asynchronous, active high.
`timescale 1ns/1ns
`default_nettype none
module pwmcc_asserts #(
   parameter CH = 4
) (
   input wire logic          core_clk,
   input wire logic          rst,
   input wire logic          clk_en,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pready,
   input wire logic [31:0]   prdata,
   input wire logic          pslverr,
   input wire logic [CH-1:0] compare_out,
   input wire logic [CH-1:0] counter_event,
   input wire logic [CH-1:0] pin_high_side,
   input wire logic [CH-1:0] pin_high_side_oe,
   input wire logic [CH-1:0] pin_low_side,
   input wire logic [CH-1:0] pin_low_side_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_ready_wait: assert property (psel && penable && !pready && clk_en |=> pready)
      else $error("pready missing after access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
      else $error("pready without access");
   a_error_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_error_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_freeze_compare: assert property (!clk_en |=> $stable(compare_out))
      else $error("compare_out moved while gated");
   a_freeze_event: assert property (!clk_en |=> $stable(counter_event))
      else $error("counter_event moved while gated");
   a_freeze_pins: assert property (!clk_en |=> $stable({pin_high_side, pin_low_side,
      pin_high_side_oe, pin_low_side_oe}))
      else $error("pins moved while gated");
   c_refused: cover property (pready && pslverr);
   c_event: cover property (counter_event[0]);
   c_resume: cover property (!clk_en ##1 clk_en);
endmodule
bind pwmcc_top pwmcc_asserts #(.CH(CH)) u_pwmcc_asserts (.core_clk(core_clk), .rst(rst),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .compare_out(compare_out), .counter_event(counter_event),
   .pin_high_side(pin_high_side), .pin_high_side_oe(pin_high_side_oe),
   .pin_low_side(pin_low_side), .pin_low_side_oe(pin_low_side_oe));
`default_nettype wire

// [verif/pwmcc_switch_model.sv]
// Power switch drivers on each output pair: resolves the pin lines.
// Assumes pins and enables registered on clk; no pull on the lines.
`timescale 1ns/1ns
`default_nettype none
module pwmcc_switch_model #(
   parameter CH = 4
) (
   input wire logic          clk,
   input wire logic [CH-1:0] hs,
   input wire logic [CH-1:0] hs_oe,
   input wire logic [CH-1:0] ls,
   input wire logic [CH-1:0] ls_oe,
   output logic [CH-1:0]     hs_line,
   output logic [CH-1:0]     ls_line
);
   logic [CH-1:0] hs_last = '0;
   logic [CH-1:0] ls_last = '0;
   // Released line shows inverse of last level, so stale values never pass
   always @(posedge clk) begin
      hs_last <= hs_line;
      ls_last <= ls_line;
   end
   assign hs_line = (hs & hs_oe) | (~hs_last & ~hs_oe);
   assign ls_line = (ls & ls_oe) | (~ls_last & ~ls_oe);
endmodule
`default_nettype wire

// [verif/pwm_clockgen_channel_comparator_bench.sv]
// Self-checking bench of pwmcc_top: APB reads queued, outputs measured.
// Assumes the register map of pwmcc_regs.vh and a 50 MHz core clock.
`include "pwmcc_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module pwm_clockgen_channel_comparator_bench;
   localparam int P = 4;
   logic        core_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, fault_in, lf;
   logic [31:0] pwdata, prdata;
   logic [3:0]  co, ev, hs, hs_oe, ls, ls_oe, hs_line, ls_line;
   logic [32:0] exp_q[$];
   int          n_mismatch = 0, n_tests = 0, gap, hi, d, k;
   int          sel_t[7] = '{0, 1, 2, 3, 10, 11, 12};
   int          x_t[7] = '{1, 2, 4, 8, 1024, 6, 5};
   int          dt_t[3];
   pwmcc_top u_pwmcc_top (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .fault_in(fault_in), .compare_out(co),
      .counter_event(ev), .pin_high_side(hs), .pin_high_side_oe(hs_oe), .pin_low_side(ls),
      .pin_low_side_oe(ls_oe));
   pwmcc_switch_model u_pwmcc_switch_model (.clk(core_clk), .hs(hs), .hs_oe(hs_oe), .ls(ls),
      .ls_oe(ls_oe), .hs_line(hs_line), .ls_line(ls_line));
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic [7:0] ca(input int ch, input int r);
      return 8'(`PWMCC_A_CH_BASE + 16 * ch + 4 * r);
   endfunction
   function automatic logic [31:0] md(input int cen, input int pol, input int event_half_select);
      return 32'((cen << `PWMCC_M_CENTER) | (pol << `PWMCC_M_POL) | (event_half_select << `PWMCC_M_CES));
   endfunction
   task automatic chk(input string what, input logic [32:0] ex, input logic [32:0] got);
      n_tests++;
      if (got !== ex) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("Error pready expected 1 seen %b", pready);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] ex);
      exp_q.push_back(ex);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic obs(input int ch);
      int n = 0;
      gap = 0;
      hi = 0;
      do begin
         @(posedge core_clk);
         #1 n++;
      end while (ev[ch] !== 1'b1 && n < 9000);
      do begin
         @(posedge core_clk);
         #1 gap++;
         hi += int'(co[ch] === 1'b1);
      end while (ev[ch] !== 1'b1 && gap < 9000);
   endtask
   task conclude;
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Read answers compared in order of issue
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready === 1'b1)
         chk("prdata", exp_q.pop_front(), {pslverr, prdata});
   end
   initial begin
      #1_500_000 n_mismatch++;
      $display("Error watchdog expected done seen hang");
      conclude();
   end
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, fault_in} = '0;
      rst = 1'b1;
      clk_en = 1'b1;
      lf = 8'h12;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rd(`PWMCC_A_CLK, 33'h0);
      for (int c = 0; c < 4; c++) rd(ca(c, `PWMCC_CH_MODE), 33'h0);
      rd(`PWMCC_A_FAULT_POLARITY, 33'(`PWMCC_FAULT_POLARITY_RST));
      rd(`PWMCC_A_FSTAT, 33'h0FC00);
      rd(8'h7C, 33'h100000000);
      lf = lfsr(lf);
      wr(`PWMCC_A_CLK, 32'h0F0F0FFF & {4{lf}});
      rd(`PWMCC_A_CLK, {1'b0, 32'h0F0F0FFF & {4{lf}}});
      lf = lfsr(lf);
      d = 1 + int'(lf) % 3;
      dt_t = '{0, d, P};
      wr(ca(0, `PWMCC_CH_PERIOD), P);
      for (int pol = 0; pol < 2; pol++) begin
         for (int i = 0; i < 3; i++) begin
            wr(`PWMCC_A_ENA, 32'h0);
            wr(ca(0, `PWMCC_CH_MODE), md(0, pol, 0));
            wr(ca(0, `PWMCC_CH_DUTY), dt_t[i]);
            wr(`PWMCC_A_ENA, 32'h1);
            obs(0);
            chk("period", P, gap);
            k = (i == 0) ? (pol ? 0 : P) : (i == 2) ? (pol ? P : 0) : (pol ? d : P - d);
            chk("high", k, hi);
         end
      end
      wr(`PWMCC_A_CLK, 32'h00050103);
      wr(ca(0, `PWMCC_CH_DUTY), d);
      for (int i = 0; i < 7; i++) begin
         wr(ca(0, `PWMCC_CH_MODE), sel_t[i]);
         obs(0);
         chk("tick", x_t[i] * P, gap);
         chk("tick_high", x_t[i] * (P - d), hi);
      end
      // Channel still on divider B: ratio zero must stop it
      wr(`PWMCC_A_CLK, 32'h00000103);
      k = 0;
      for (int i = 0; i < 200; i++) begin
         @(posedge core_clk);
         #1 k += int'(ev[0] === 1'b1);
      end
      chk("stopped", 0, k);
      for (int c = 0; c < 2; c++) begin
         wr(ca(0, `PWMCC_CH_MODE), md(1, 0, c));
         obs(0);
         chk("center", c ? P : 2 * P, gap);
      end
      wr(ca(0, `PWMCC_CH_MODE), md(0, 0, 0));
      wr(`PWMCC_A_SYNC, 32'h2);
      wr(ca(1, `PWMCC_CH_MODE), 32'hF);
      wr(ca(1, `PWMCC_CH_PERIOD), P);
      wr(ca(1, `PWMCC_CH_DUTY), d);
      wr(`PWMCC_A_ENA, 32'h3);
      obs(0);
      k = 0;
      for (int i = 0; i < 2 * P; i++) begin
         @(posedge core_clk);
         #1 k += int'(co[1] === 1'b1);
      end
      chk("follow", 2 * (P - d), k);
      @(posedge core_clk);
      clk_en <= 1'b0;
      repeat (20) @(posedge core_clk);
      clk_en <= 1'b1;
      obs(0);
      chk("resume", P, gap);
      rd(`PWMCC_A_EVT, 33'h1);
      // Zero dead time still leaves one both-low cycle per edge
      wr(ca(0, `PWMCC_CH_MODE), 32'h00010000);
      obs(0);
      k = 0;
      for (int i = 0; i < 2 * P; i++) begin
         @(posedge core_clk);
         #1 k += int'(hs[0] === 1'b0 && ls[0] === 1'b0);
      end
      chk("deadtime", 4, k);
      wr(`PWMCC_A_OVR, 32'h101);
      repeat (2) @(posedge core_clk);
      #1 chk("override", 4'b0101, {hs[0], ls[0], hs_line[0], ls_line[0]});
      wr(`PWMCC_A_FVAL, 32'h1);
      wr(`PWMCC_A_FAULT_POLARITY, 32'h7);
      wr(ca(0, `PWMCC_CH_MODE), 32'h04000000);
      fault_in <= 8'h04;
      repeat (3) @(posedge core_clk);
      #1 chk("fault", 4'b1010, {hs[0], ls[0], hs_line[0], ls_line[0]});
      rd(`PWMCC_A_FSTAT, 33'h0FC04);
      wr(`PWMCC_A_FVAL, 32'h101);
      repeat (2) @(posedge core_clk);
      #1 chk("release", 2'b01, {hs_oe[0], ls_oe[0]});
      fault_in <= 8'h00;
      wr(`PWMCC_A_OVR, 32'h0);
      repeat (4) @(posedge core_clk);
      conclude();
   end
endmodule
`default_nettype wire
